// *** rtl/rpd_defines.vh ***
`ifndef RPD_DEFINES_VH
`define RPD_DEFINES_VH
// ------------------------------------------------------------
// apb register offsets
// ------------------------------------------------------------
`define RPD_OFF_WAKE_EN    12'h000
`define RPD_OFF_WAKE_COND  12'h004
`define RPD_OFF_INT_WAKE   12'h008
`define RPD_OFF_STATUS     12'h00c
`define RPD_OFF_CTRL       12'h010
`define RPD_OFF_PORT       12'h014
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define RPD_ST_POWER_FLAG  0
`define RPD_ST_T3_FLAG     1
`define RPD_ST_SUPPLY_EN   2
`define RPD_ST_ARMED       3
`define RPD_ST_MODE_LO     4
`define RPD_ST_MODE_HI     5
`define RPD_CTRL_T3_CLR    0
`define RPD_CTRL_CSEL_LO   1
`define RPD_CTRL_CSEL_HI   2
// ------------------------------------------------------------
// reset values, counter input select code and back-up stack level
// ------------------------------------------------------------
`define RPD_RST_WAKE       4'h0
`define RPD_RST_LATCH      4'hf
`define RPD_RST_PULLUP     4'h0
`define RPD_RST_PUSHPULL   4'h0
`define RPD_RST_IRQCTRL    4'h0
`define RPD_CSEL_INPUT     2'h3
`define RPD_STACK_BACKUP   3'h7
`endif

// *** rtl/rpd_reset_power_ctrl.v ***
`timescale 1ns/10ps
`include "rpd_defines.vh"
module rpd_reset_power_ctrl #(
  parameter HAS_DETECTOR = 1
) (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        pclk_unused_tie,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        resetPinN,
  input  wire        watchdogReset,
  input  wire        supplyDropDetect,
  input  wire [3:0]  port0Pins,
  input  wire [3:0]  port1Pins,
  input  wire        intPin,
  input  wire        intLevelHigh,
  input  wire        supplyDropEnableInstr,
  input  wire        powerDownArmInstr,
  input  wire        clockOperatingHaltInstr,
  input  wire        ramBackupHaltInstr,
  input  wire        powerFlagSkipInstr,
  input  wire        timer3Underflow,
  input  wire        timer3FlagClear,
  input  wire [3:0]  accData,
  input  wire        wakeReg0WriteInstr,
  input  wire        wakeReg1WriteInstr,
  input  wire        wakeReg2WriteInstr,
  input  wire        wakeReg0ReadInstr,
  input  wire        wakeReg1ReadInstr,
  input  wire        wakeReg2ReadInstr,
  input  wire        counterOutIn,
  input  wire        counterOeIn,
  output reg  [3:0]  accReadData,
  output reg         skipTaken,
  output wire        coreClockRun,
  output wire        oscillatorStop,
  output wire        detectorActive,
  output reg         pcLoadZero,
  output reg         stateInit,
  output reg         stackLevel7,
  output reg  [3:0]  irqCtrlOne,
  output wire        lcTimerRun,
  output wire        lcdOff,
  output reg         powerFlag,
  output wire        timer3RequestFlag,
  output wire [3:0]  portLatch,
  output wire [3:0]  portPullUp,
  output wire [3:0]  portPushPull,
  output wire [3:0]  portOe,
  output wire        counterPinOut,
  output wire        counterPinOe
);

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [1:0] ST_RUN    = 2'b00;
  localparam [1:0] ST_CLKOP  = 2'b01;
  localparam [1:0] ST_BACKUP = 2'b10;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  reg [10:0] pinMeta_ff;
  reg [10:0] pinSync_ff;
  reg [8:0]  pinPrev_ff;
  wire [10:0] pinRaw = {supplyDropDetect, resetPinN, intPin, port1Pins, port0Pins};

  always @(posedge core_clk) begin
    if (rst) begin
      pinMeta_ff <= 11'h7ff;
      pinSync_ff <= 11'h7ff;
      pinPrev_ff <= 9'h1ff;
    end else begin
      pinMeta_ff <= pinRaw;
      pinSync_ff <= pinMeta_ff;
      pinPrev_ff <= pinSync_ff[8:0];
    end
  end

  wire [3:0] p0Now    = pinSync_ff[3:0];
  wire [3:0] p1Now    = pinSync_ff[7:4];
  wire       intNow   = pinSync_ff[8];
  wire       rstPinN  = pinSync_ff[9];
  wire       dropNow  = pinSync_ff[10];

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  reg [3:0] wakeEnable_ff;
  reg [3:0] wakeCondition_ff;
  reg [3:0] intPinWake_ff;
  reg [3:0] latch_ff;
  reg [3:0] pullUp_ff;
  reg [3:0] pushPull_ff;
  reg [1:0] counterSel_ff;
  reg [1:0] mode_ff;
  reg       armed_ff;
  reg       supplyEn_ff;
  reg       t3Flag_ff;
  reg       portsReleased_ff;

  // cold start sources
  wire dropReset = (HAS_DETECTOR != 0) && !dropNow &&
                   ((mode_ff == ST_RUN) || supplyEn_ff);
  wire coldReq   = !rstPinN || watchdogReset || dropReset;
  wire sysReset  = rst || coldReq;

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  wire apbWr = psel && penable && pwrite;
  wire [11:0] off = {paddr[11:2], 2'b00};
  wire hit = (off == `RPD_OFF_WAKE_EN) || (off == `RPD_OFF_WAKE_COND) ||
             (off == `RPD_OFF_INT_WAKE) || (off == `RPD_OFF_STATUS) ||
             (off == `RPD_OFF_CTRL) || (off == `RPD_OFF_PORT);

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  reg [31:0] nxt_prdata;

  always @* begin
    case (off)
      `RPD_OFF_WAKE_EN:   nxt_prdata = {28'h0, wakeEnable_ff};
      `RPD_OFF_WAKE_COND: nxt_prdata = {28'h0, wakeCondition_ff};
      `RPD_OFF_INT_WAKE:  nxt_prdata = {28'h0, intPinWake_ff};
      `RPD_OFF_STATUS:    nxt_prdata = {26'h0, mode_ff, armed_ff, supplyEn_ff,
                                        t3Flag_ff, powerFlag};
      `RPD_OFF_CTRL:      nxt_prdata = {29'h0, counterSel_ff, 1'b0};
      `RPD_OFF_PORT:      nxt_prdata = {20'h0, pushPull_ff, pullUp_ff, latch_ff};
      default:            nxt_prdata = 32'h0;
    endcase
  end

  // ------------------------------------------------------------
  // read data, captured in the setup cycle
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= nxt_prdata;
    end
  end

  // ------------------------------------------------------------
  // wakeup registers, accumulator side and bus side
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    if (sysReset) begin
      wakeEnable_ff    <= `RPD_RST_WAKE;
      wakeCondition_ff <= `RPD_RST_WAKE;
      intPinWake_ff    <= `RPD_RST_WAKE;
      accReadData      <= 4'h0;
    end else begin
      if (wakeReg0WriteInstr) begin
        wakeEnable_ff <= accData;
      end else if (apbWr && off == `RPD_OFF_WAKE_EN) begin
        wakeEnable_ff <= pwdata[3:0];
      end
      if (wakeReg1WriteInstr) begin
        wakeCondition_ff <= accData;
      end else if (apbWr && off == `RPD_OFF_WAKE_COND) begin
        wakeCondition_ff <= pwdata[3:0];
      end
      if (wakeReg2WriteInstr) begin
        intPinWake_ff <= accData;
      end else if (apbWr && off == `RPD_OFF_INT_WAKE) begin
        intPinWake_ff <= pwdata[3:0];
      end
      if (wakeReg0ReadInstr) begin
        accReadData <= wakeEnable_ff;
      end else if (wakeReg1ReadInstr) begin
        accReadData <= wakeCondition_ff;
      end else if (wakeReg2ReadInstr) begin
        accReadData <= intPinWake_ff;
      end
    end
  end

  // ------------------------------------------------------------
  // port format and counter select
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    if (sysReset) begin
      latch_ff         <= `RPD_RST_LATCH;
      pullUp_ff        <= `RPD_RST_PULLUP;
      pushPull_ff      <= `RPD_RST_PUSHPULL;
      portsReleased_ff <= 1'b0;
      counterSel_ff    <= 2'h0;
    end else if (apbWr && off == `RPD_OFF_PORT) begin
      latch_ff         <= pwdata[3:0];
      pullUp_ff        <= pwdata[7:4];
      pushPull_ff      <= pwdata[11:8];
      portsReleased_ff <= 1'b1;
    end else if (apbWr && off == `RPD_OFF_CTRL) begin
      counterSel_ff    <= pwdata[`RPD_CTRL_CSEL_HI:`RPD_CTRL_CSEL_LO];
    end
  end

  // ports keep their levels in both power-down modes
  assign portLatch    = latch_ff;
  assign portPullUp   = pullUp_ff;
  assign portPushPull = pushPull_ff;
  assign portOe       = portsReleased_ff ? ~latch_ff | pushPull_ff : 4'h0;

  wire inBackup = (mode_ff == ST_BACKUP);
  assign counterPinOut = inBackup ? 1'b0 : counterOutIn;
  assign counterPinOe  = inBackup ? (counterSel_ff != `RPD_CSEL_INPUT)
                                  : counterOeIn;

  // ------------------------------------------------------------
  // timer 3 request flag
  // ------------------------------------------------------------
  wire t3Clear = timer3FlagClear ||
                 (apbWr && off == `RPD_OFF_CTRL && pwdata[`RPD_CTRL_T3_CLR]);

  always @(posedge core_clk) begin
    if (sysReset) begin
      t3Flag_ff <= 1'b0;
    end else if (timer3Underflow && !inBackup) begin
      t3Flag_ff <= 1'b1;
    end else if (t3Clear) begin
      t3Flag_ff <= 1'b0;
    end
  end
  assign timer3RequestFlag = t3Flag_ff;

  // ------------------------------------------------------------
  // wakeup detection
  // ------------------------------------------------------------
  wire [3:0] p0Fall = pinPrev_ff[3:0] & ~p0Now;
  wire [3:0] p1Hit;
  wire [3:0] p0Hit;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gWake
      wire condBit = wakeCondition_ff[(g / 2) * 2];
      wire polBit  = wakeCondition_ff[(g / 2) * 2 + 1];
      wire p1Edge  = (pinPrev_ff[4 + g] != p1Now[g]) && (p1Now[g] == polBit);
      wire p1Level = (p1Now[g] == polBit);
      assign p0Hit[g] = wakeEnable_ff[g / 2] && p0Fall[g];
      assign p1Hit[g] = wakeEnable_ff[2 + g / 2] && (condBit ? p1Level : p1Edge);
    end
  endgenerate

  wire intEdge  = (pinPrev_ff[8] != intNow) && (intNow == intLevelHigh);
  wire intLevel = (intNow == intLevelHigh);
  wire intHit   = intPinWake_ff[0] && (intPinWake_ff[1] ? intEdge : intLevel);
  wire extWake  = (|p0Hit) || (|p1Hit) || intHit;

  wire wakeNow = (mode_ff == ST_CLKOP) ? (extWake || t3Flag_ff)
                                       : extWake;

  // ------------------------------------------------------------
  // power-down sequencer
  // ------------------------------------------------------------
  reg [1:0] nxt_mode;
  reg       nxt_armed;
  reg       enterPd;
  reg       wakeEvt;

  always @* begin
    nxt_mode  = mode_ff;
    nxt_armed = armed_ff;
    enterPd   = 1'b0;
    wakeEvt   = 1'b0;
    case (mode_ff)
      ST_RUN: begin
        if (powerDownArmInstr) begin
          nxt_armed = 1'b1;
        end
        if (clockOperatingHaltInstr && armed_ff) begin
          nxt_mode  = ST_CLKOP;
          nxt_armed = 1'b0;
          enterPd   = 1'b1;
        end else if (ramBackupHaltInstr && armed_ff) begin
          nxt_mode  = ST_BACKUP;
          nxt_armed = 1'b0;
          enterPd   = 1'b1;
        end
        // halts with no arm fall through unchanged
      end
      ST_CLKOP, ST_BACKUP: begin
        if (wakeNow) begin
          nxt_mode = ST_RUN;
          wakeEvt  = 1'b1;
        end
      end
      default: begin
        nxt_mode = ST_RUN;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (sysReset) begin
      mode_ff     <= ST_RUN;
      armed_ff    <= 1'b0;
      supplyEn_ff <= 1'b0;
      powerFlag   <= 1'b0;
      pcLoadZero  <= 1'b1;
      stateInit   <= 1'b1;
      stackLevel7 <= 1'b0;
      irqCtrlOne  <= `RPD_RST_IRQCTRL;
      skipTaken   <= 1'b0;
    end else begin
      mode_ff    <= nxt_mode;
      armed_ff   <= nxt_armed;
      if (supplyDropEnableInstr) begin
        supplyEn_ff <= 1'b1;
      end
      if (wakeEvt) begin
        powerFlag <= 1'b1;
      end
      pcLoadZero <= wakeEvt || enterPd;
      stateInit  <= enterPd;
      if (enterPd) begin
        stackLevel7 <= (nxt_mode == ST_BACKUP);
        irqCtrlOne  <= `RPD_RST_IRQCTRL;
      end else if (wakeEvt) begin
        stackLevel7 <= 1'b0;
      end
      skipTaken <= powerFlagSkipInstr && powerFlag;
    end
  end

  // ------------------------------------------------------------
  // clock and block enables
  // ------------------------------------------------------------
  assign coreClockRun   = (mode_ff == ST_RUN);
  assign oscillatorStop = inBackup;
  assign lcTimerRun     = !inBackup;
  assign lcdOff         = inBackup;
  assign detectorActive = (HAS_DETECTOR != 0) &&
                          ((mode_ff == ST_RUN) || supplyEn_ff);

endmodule // rpd_reset_power_ctrl

// *** bench/rpd_reset_power_ctrl_asserts.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// power sequencer checks
// ------------------------------------------------------------
module rpd_reset_power_ctrl_asserts (
  input wire       core_clk,
  input wire       rst,
  input wire       powerDownArmInstr,
  input wire       ramBackupHaltInstr,
  input wire       powerFlagSkipInstr,
  input wire       skipTaken,
  input wire       coreClockRun,
  input wire       oscillatorStop,
  input wire       pcLoadZero,
  input wire       stateInit,
  input wire       stackLevel7,
  input wire [3:0] irqCtrlOne,
  input wire       lcdOff,
  input wire       powerFlag,
  input wire       timer3RequestFlag,
  input wire [3:0] portLatch,
  input wire [3:0] portPullUp,
  input wire       counterPinOut,
  input wire       counterPinOe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_rst_port; $fell(rst) |-> portLatch == 4'hf && portPullUp == 4'h0; endproperty
  a_rst_port: assert property (p_rst_port) else $error("port reset state wrong");
  property p_rst_pc; $fell(rst) |-> pcLoadZero && stateInit; endproperty
  a_rst_pc: assert property (p_rst_pc) else $error("no start address load");
  property p_rst_flag; $fell(rst) |-> irqCtrlOne == 4'h0 && !powerFlag; endproperty
  a_rst_flag: assert property (p_rst_flag) else $error("reset flags wrong");
  property p_enter;
    powerDownArmInstr ##[1:2] (ramBackupHaltInstr && coreClockRun) |=>
      oscillatorStop && !coreClockRun;
  endproperty
  a_enter: assert property (p_enter) else $error("back-up not entered");
  property p_init; $fell(coreClockRun) |-> ##[0:1] (pcLoadZero && stateInit); endproperty
  a_init: assert property (p_init) else $error("entry init missing");
  property p_stack; $fell(coreClockRun) && oscillatorStop |-> ##[0:1] stackLevel7; endproperty
  a_stack: assert property (p_stack) else $error("stack level not set");
  property p_backup; oscillatorStop |-> lcdOff && !coreClockRun && stackLevel7; endproperty
  a_backup: assert property (p_backup) else $error("back-up state wrong");
  property p_counter_pin; oscillatorStop && counterPinOe |-> !counterPinOut; endproperty
  a_counter_pin: assert property (p_counter_pin) else $error("counter pin not low");
  property p_warm; $rose(coreClockRun) && !stateInit |-> powerFlag ##[0:1] pcLoadZero; endproperty
  a_warm: assert property (p_warm) else $error("warm start wrong");
  property p_skip; powerFlagSkipInstr |=> skipTaken == $past(powerFlag); endproperty
  a_skip: assert property (p_skip) else $error("skip result wrong");
  property p_t3;
    timer3RequestFlag && !coreClockRun && !oscillatorStop |-> ##[1:2] coreClockRun;
  endproperty
  a_t3: assert property (p_t3) else $error("timer return missing");
  c_backup: cover property ($rose(oscillatorStop));
  c_warm: cover property ($rose(powerFlag));
  c_t3: cover property (timer3RequestFlag && !coreClockRun);
endmodule // rpd_reset_power_ctrl_asserts
bind rpd_reset_power_ctrl rpd_reset_power_ctrl_asserts i_chk (.*);

// *** bench/rpd_wake_source.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// wake pins and reset sources
// ------------------------------------------------------------
module rpd_wake_source (
  input  wire       core_clk,
  output reg        resetPinN,
  output reg        supplyDropDetect,
  output reg  [3:0] port0Pins,
  output reg  [3:0] port1Pins,
  output reg        intPin
);
  initial begin
    {resetPinN, supplyDropDetect, intPin} = 3'b110;
    {port0Pins, port1Pins} = 8'hff;
  end
  // key pressed low, released to pull-up level
  task keyPress(input int pin, input int hold);
    @(posedge core_clk);
    port0Pins[pin] <= 1'b0;
    repeat (hold) @(posedge core_clk);
    port0Pins[pin] <= 1'b1;
  endtask
  // low pulse: 0 reset pin, 1 supply detector
  task drop(input int src, input int len);
    @(posedge core_clk);
    if (src == 0) resetPinN <= 1'b0;
    else supplyDropDetect <= 1'b0;
    repeat (len) @(posedge core_clk);
    {resetPinN, supplyDropDetect} <= 2'b11;
  endtask
endmodule // rpd_wake_source

// *** bench/rpd_reset_power_ctrl_test.sv ***
`timescale 1ns/10ps
`include "rpd_defines.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
`define PULSES {supplyDropEnableInstr, powerDownArmInstr, clockOperatingHaltInstr, \
  ramBackupHaltInstr, powerFlagSkipInstr, timer3Underflow, timer3FlagClear, watchdogReset, \
  wakeReg0WriteInstr, wakeReg1WriteInstr, wakeReg2WriteInstr, wakeReg0ReadInstr, \
  wakeReg1ReadInstr, wakeReg2ReadInstr}
// ------------------------------------------------------------
// power sequencer bench
// ------------------------------------------------------------
module rpd_reset_power_ctrl_test;
  localparam int ARM = 0, HALT1 = 1, HALT2 = 2, SKIP = 3, T3UF = 4, T3CLR = 5, SUPEN = 6;
  logic core_clk, rst, pclk_unused_tie, psel, penable, pwrite, intLevelHigh, err;
  logic supplyDropEnableInstr, powerDownArmInstr, clockOperatingHaltInstr, ramBackupHaltInstr;
  logic powerFlagSkipInstr, timer3Underflow, timer3FlagClear, watchdogReset;
  logic wakeReg0WriteInstr, wakeReg1WriteInstr, wakeReg2WriteInstr, counterOutIn;
  logic wakeReg0ReadInstr, wakeReg1ReadInstr, wakeReg2ReadInstr, counterOeIn;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [3:0]  accData;
  wire pready, pslverr, resetPinN, supplyDropDetect, intPin, skipTaken, coreClockRun;
  wire oscillatorStop, detectorActive, pcLoadZero, stateInit, stackLevel7, lcTimerRun, lcdOff;
  wire powerFlag, timer3RequestFlag, counterPinOut, counterPinOe;
  wire [31:0] prdata;
  wire [3:0]  port0Pins, port1Pins, accReadData, irqCtrlOne, portLatch, portPullUp;
  wire [3:0]  portPushPull, portOe;
  int failures, cmp_count;
  rpd_reset_power_ctrl i_dut (.*);
  rpd_wake_source i_src (.*);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task results;
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task pulse(input int k);
    @(posedge core_clk);
    case (k)
      ARM: powerDownArmInstr <= 1'b1;
      HALT1: clockOperatingHaltInstr <= 1'b1;
      HALT2: ramBackupHaltInstr <= 1'b1;
      SKIP: powerFlagSkipInstr <= 1'b1;
      T3UF: timer3Underflow <= 1'b1;
      T3CLR: timer3FlagClear <= 1'b1;
      SUPEN: supplyDropEnableInstr <= 1'b1;
      7: watchdogReset <= 1'b1;
      8: wakeReg0WriteInstr <= 1'b1;
      9: wakeReg1WriteInstr <= 1'b1;
      10: wakeReg2WriteInstr <= 1'b1;
      11: wakeReg0ReadInstr <= 1'b1;
      12: wakeReg1ReadInstr <= 1'b1;
      default: wakeReg2ReadInstr <= 1'b1;
    endcase
    @(posedge core_clk);
    `PULSES <= '0;
    #1;
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin failures++; results(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task waitRun(input logic want);
    int n;
    n = 0;
    #1;
    while (coreClockRun !== want && n < 60) begin @(posedge core_clk); #1; n++; end
    if (n >= 60) begin failures++; results(); end
  endtask
  task tReset;
    `CHK("latch", 4'hf, portLatch)
    `CHK("pullUp", 8'h00, {portPullUp, portPushPull})
    `CHK("portOe", 4'h0, portOe)
    `CHK("irqCtrl", 4'h0, irqCtrlOne)
    `CHK("pcLoad", 1'b1, pcLoadZero)
    apb(0, `RPD_OFF_STATUS, 0);
    `CHK("pflag", 1'b0, rd[0])
  endtask
  task tRegs;
    for (int k = 0; k < 3; k++) begin
      accData <= 4'h8 + 4'(k);
      pulse(8 + k);
      pulse(11 + k);
      `CHK("accRead", 4'h8 + 4'(k), accReadData)
      apb(0, 12'(4 * k), 0);
      `CHK("wakeApb", 32'(4'h8 + 4'(k)), rd)
    end
    apb(1, `RPD_OFF_WAKE_EN, 32'h1);
    apb(0, 12'h018, 0);
    `CHK("unmapped", 33'h1_0000_0000, {err, rd})
  endtask
  task tNoArm;
    pulse(HALT1);
    pulse(HALT2);
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("noArm", 1'b1, coreClockRun)
  endtask
  task tBackup;
    for (int i = 0; i < 2; i++) begin
      apb(1, `RPD_OFF_CTRL, i ? 32'h6 : 32'h0);
      pulse(ARM);
      pulse(HALT2);
      waitRun(0);
      `CHK("backup", 3'b111, {oscillatorStop, lcdOff, stackLevel7})
      `CHK("lcTimer", 1'b0, lcTimerRun)
      `CHK("cntrOe", i ? 1'b0 : 1'b1, counterPinOe)
      if (i == 0) `CHK("cntrOut", 1'b0, counterPinOut)
      pulse(T3UF);
      repeat (4) @(posedge core_clk);
      #1;
      `CHK("t3Ignored", 1'b0, coreClockRun)
      i_src.keyPress(i, 3);
      waitRun(1);
      `CHK("warm", 1'b1, powerFlag)
      pulse(SKIP);
      `CHK("skip", 1'b1, skipTaken)
      apb(0, `RPD_OFF_WAKE_EN, 0);
      `CHK("retain", 32'h1, rd)
    end
  endtask
  task tClock;
    pulse(ARM);
    pulse(HALT1);
    waitRun(0);
    `CHK("clkMode", 2'b01, {oscillatorStop, lcTimerRun})
    pulse(T3UF);
    waitRun(1);
    `CHK("t3Wake", 1'b1, timer3RequestFlag)
    pulse(ARM);
    pulse(HALT1);
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("t3Return", 1'b1, coreClockRun)
    pulse(T3CLR);
    `CHK("t3Clear", 1'b0, timer3RequestFlag)
  endtask
  task tCold;
    pulse(7);
    repeat (4) @(posedge core_clk);
    #1;
    `CHK("wdog", 1'b0, powerFlag)
    pulse(SUPEN);
    pulse(SUPEN);
    apb(0, `RPD_OFF_STATUS, 0);
    `CHK("supEnOn", 1'b1, rd[2])
    pulse(ARM);
    pulse(HALT1);
    waitRun(0);
    `CHK("detector", 1'b1, detectorActive)
    i_src.drop(1, 4);
    waitRun(1);
    repeat (4) @(posedge core_clk);
    apb(0, `RPD_OFF_STATUS, 0);
    `CHK("supEnOff", 3'h0, rd[2:0])
    apb(1, `RPD_OFF_PORT, 32'h0);
    i_src.drop(0, 4);
    repeat (6) @(posedge core_clk);
    #1;
    `CHK("pinCold", 4'hf, portLatch)
  endtask
  initial begin
    {rst, pclk_unused_tie, psel, penable, pwrite, intLevelHigh} = 6'b100000;
    {paddr, pwdata, accData} = '0;
    `PULSES = '0;
    {counterOutIn, counterOeIn} = 2'b11;
    failures = 0;
    cmp_count = 0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    tReset();
    tRegs();
    tNoArm();
    tBackup();
    tClock();
    tCold();
    results();
  end
endmodule // rpd_reset_power_ctrl_test
